// [urx_defs.svh]
// Purpose: Constants of the receive block: sample counts, vote points, reset values.
// Assumes: Included by bare name from the design files.
// Notes: Definitions only.
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH

// ---------------------------------------------------------------
// Oversampling
// ---------------------------------------------------------------
`define URX_SMP_NORMAL 5'd16
`define URX_SMP_DOUBLE 5'd8
`define URX_VOTE_NORMAL 5'd8
`define URX_VOTE_DOUBLE 5'd4

// ---------------------------------------------------------------
// Character format
// ---------------------------------------------------------------
`define URX_DATA_BITS 4'd8
`define URX_NINE_BITS 4'd9

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define URX_RST_RXDATA 8'h00
`define URX_RST_TXDATA 9'h000
`define URX_RST_NINTH 1'b1
`define URX_LINE_IDLE 1'b1

`endif

// [urx_pkg.sv]
// Purpose: Types shared by the receive block.
// Assumes: Nothing.
// Notes: Constants live in urx_defs.svh.
package urx_pkg;

  typedef enum logic [1:0] {
    URX_IDLE = 2'b00,
    URX_START = 2'b01,
    URX_DATA = 2'b10,
    URX_STOP = 2'b11
  } urx_state_e;

  typedef logic [7:0] urx_byte_t;
  typedef logic [8:0] urx_word_t;

endpackage : urx_pkg

// [urx_smp_if.sv]
// Purpose: Carrier between the frame controller and the line sampler.
// Assumes: One clock domain.
// Notes: No clocking block.
`timescale 1ns/1ps
interface urx_smp_if;
  logic tick;
  logic double;
  logic arm;
  logic run;
  logic line;
  logic bit_done;
  logic bit_val;

  modport sampler (input tick, input double, input arm, input run, output line, output bit_done, output bit_val);
  modport ctrl (output tick, output double, output arm, output run, input line, input bit_done, input bit_val);
endinterface : urx_smp_if

// [urx_sampler.sv]
// Purpose: Synchronise the receive pin, count samples per bit, majority-vote the centre.
// Assumes: tick is one clock wide at 16 (or 8) times the baud rate.
// Notes: bit_done pulses one clock after the last vote sample.
`timescale 1ns/1ps
`include "urx_defs.svh"
module urx_sampler (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic serial_in_pin,
  urx_smp_if.sampler smp
);
  import urx_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic line_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= `URX_LINE_IDLE;
      s2_reg <= `URX_LINE_IDLE;
      s3_reg <= `URX_LINE_IDLE;
      line_reg <= `URX_LINE_IDLE;
    end else begin
      s1_reg <= serial_in_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // Only a level seen twice in a row is taken
      if (s2_reg == s3_reg) begin
        line_reg <= s3_reg;
      end
    end
  end

  assign smp.line = line_reg;

  // ---------------------------------------------------------------
  // Sample counter and vote
  // ---------------------------------------------------------------
  logic [4:0] cnt_reg;
  logic [4:0] idx_next;
  logic [4:0] last_smp;
  logic [4:0] vote_first;
  logic [1:0] votes_reg;
  logic done_reg;
  logic val_reg;

  assign last_smp = smp.double ? `URX_SMP_DOUBLE : `URX_SMP_NORMAL;
  assign vote_first = smp.double ? `URX_VOTE_DOUBLE : `URX_VOTE_NORMAL;
  assign idx_next = (cnt_reg == last_smp) ? 5'd1 : 5'(cnt_reg + 5'd1);

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 5'd0;
    end else if (smp.arm) begin
      cnt_reg <= 5'd1;
    end else if (smp.tick && smp.run) begin
      cnt_reg <= idx_next;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      votes_reg <= 2'd0;
      done_reg <= 1'b0;
      val_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (smp.tick && smp.run && !smp.arm) begin
        if (idx_next == vote_first) begin
          votes_reg <= {1'b0, line_reg};
        end else if (idx_next == 5'(vote_first + 5'd1)) begin
          votes_reg <= 2'(votes_reg + {1'b0, line_reg});
        end else if (idx_next == 5'(vote_first + 5'd2)) begin
          val_reg <= (2'(votes_reg + {1'b0, line_reg}) >= 2'd2);
          done_reg <= 1'b1;
        end
      end
    end
  end

  assign smp.bit_done = done_reg;
  assign smp.bit_val = val_reg;

  AST_DONE_SINGLE: assert property (@(posedge clock) disable iff (sys_rst) done_reg |=> !done_reg)
    else $error("bit strobe lasted two cycles");
  AST_ARM_RESTART: assert property (@(posedge clock) disable iff (sys_rst) smp.arm |=> cnt_reg == 5'd1)
    else $error("sample count not restarted at start edge");

endmodule : urx_sampler

// [urx_top.sv]
// Purpose: Receive side of an asynchronous serial port with pin takeover and address filtering.
// Assumes: sample_tick is one clock wide at sixteen times the baud rate, eight in double speed.
// Notes: Control and status bits are plain ports; pin outputs are registered.
`timescale 1ns/1ps
`include "urx_defs.svh"
module urx_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sample_tick,
  input wire logic rx_enable_bit,
  input wire logic tx_enable_bit,
  input wire logic nine_bit_select,
  input wire logic multiproc_mode_bit,
  input wire logic double_speed_bit,
  input wire logic tx_ninth_bit,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire urx_pkg::urx_byte_t wr_data,
  input wire logic tx_line_bit,
  input wire logic serial_in_pin,
  input wire logic port_d_dir_bit0,
  input wire logic port_d_dir_bit1,
  input wire logic port_d_out_bit0,
  input wire logic port_d_out_bit1,
  output urx_pkg::urx_byte_t serial_data_reg,
  output urx_pkg::urx_word_t tx_data_reg,
  output logic tx_data_written,
  output logic rx_complete_flag,
  output logic frame_error_flag,
  output logic overrun_flag,
  output logic rx_ninth_bit,
  output logic port_d_line0_out,
  output logic port_d_line0_oe,
  output logic port_d_line0_pullup,
  output logic port_d_line1_out,
  output logic port_d_line1_oe
);
  import urx_pkg::*;

  // ---------------------------------------------------------------
  // Line sampler
  // ---------------------------------------------------------------
  urx_smp_if smp ();

  urx_state_e state_reg;
  logic arm;

  // Hunting only while enabled, so a disabled receiver never arms
  assign arm = rx_enable_bit && (state_reg == URX_IDLE) && sample_tick && !smp.line;
  assign smp.tick = sample_tick;
  assign smp.double = double_speed_bit;
  assign smp.arm = arm;
  assign smp.run = rx_enable_bit && (state_reg != URX_IDLE);

  urx_sampler u_sampler (
    .clock(clock),
    .sys_rst(sys_rst),
    .serial_in_pin(serial_in_pin),
    .smp(smp.sampler)
  );

  // ---------------------------------------------------------------
  // Frame sequencer
  // ---------------------------------------------------------------
  logic [3:0] bit_cnt_reg;
  logic [3:0] nbits;
  logic [8:0] shift_reg;

  assign nbits = nine_bit_select ? `URX_NINE_BITS : `URX_DATA_BITS;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= URX_IDLE;
    end else if (!rx_enable_bit) begin
      state_reg <= URX_IDLE;
    end else begin
      unique case (state_reg)
        URX_IDLE: begin
          if (arm) begin
            state_reg <= URX_START;
          end
        end
        URX_START: begin
          if (smp.bit_done) begin
            state_reg <= smp.bit_val ? URX_IDLE : URX_DATA;
          end
        end
        URX_DATA: begin
          if (smp.bit_done && (bit_cnt_reg == 4'(nbits - 4'd1))) begin
            state_reg <= URX_STOP;
          end
        end
        URX_STOP: begin
          if (smp.bit_done) begin
            state_reg <= URX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_reg <= 4'd0;
      shift_reg <= 9'h000;
    end else if (state_reg == URX_START) begin
      bit_cnt_reg <= 4'd0;
    end else if (state_reg == URX_DATA && smp.bit_done) begin
      bit_cnt_reg <= 4'(bit_cnt_reg + 4'd1);
      // LSB first; eight-bit data ends up in the upper eight positions
      shift_reg <= {smp.bit_val, shift_reg[8:1]};
    end
  end

  // ---------------------------------------------------------------
  // Completion decisions
  // ---------------------------------------------------------------
  logic frame_end;
  logic stop_ok;
  logic is_addr;
  logic ignore;
  logic unread;
  logic accept;
  logic over_evt;
  urx_byte_t rx_byte;

  assign frame_end = rx_enable_bit && (state_reg == URX_STOP) && smp.bit_done;
  assign stop_ok = smp.bit_val;
  assign rx_byte = nine_bit_select ? shift_reg[7:0] : shift_reg[8:1];
  assign is_addr = nine_bit_select ? shift_reg[8] : stop_ok;
  assign ignore = frame_end && multiproc_mode_bit && !is_addr;
  // A read in the same cycle frees the holding register, so nothing is lost
  assign unread = rx_complete_flag && !data_rd;
  assign accept = frame_end && !ignore && !unread;
  assign over_evt = frame_end && !ignore && unread;

  // ---------------------------------------------------------------
  // Receive holding register and flags
  // ---------------------------------------------------------------
  logic or_pending_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      serial_data_reg <= `URX_RST_RXDATA;
    end else if (accept) begin
      serial_data_reg <= rx_byte;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ninth_bit <= `URX_RST_NINTH;
    end else if (accept && nine_bit_select) begin
      rx_ninth_bit <= shift_reg[8];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_complete_flag <= 1'b0;
    end else if (accept) begin
      rx_complete_flag <= 1'b1;
    end else if (data_rd) begin
      rx_complete_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      frame_error_flag <= 1'b0;
    end else if (accept) begin
      // Set on a low stop, cleared by a high one
      frame_error_flag <= !stop_ok;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      or_pending_reg <= 1'b0;
    end else if (over_evt) begin
      or_pending_reg <= 1'b1;
    end else if (data_rd) begin
      or_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      overrun_flag <= 1'b0;
    end else if (data_rd) begin
      // Overrun becomes visible only once the held byte is read
      overrun_flag <= or_pending_reg || over_evt;
    end else if (accept) begin
      overrun_flag <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transmit data register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_data_reg <= `URX_RST_TXDATA;
      tx_data_written <= 1'b0;
    end else begin
      tx_data_written <= data_wr;
      if (data_wr) begin
        // Ninth bit is latched with the byte, so it must be set first
        tx_data_reg <= {tx_ninth_bit, wr_data};
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin takeover
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port_d_line1_out <= `URX_LINE_IDLE;
      port_d_line1_oe <= 1'b0;
    end else begin
      port_d_line1_out <= tx_enable_bit ? tx_line_bit : port_d_out_bit1;
      port_d_line1_oe <= tx_enable_bit || port_d_dir_bit1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      port_d_line0_out <= 1'b0;
      port_d_line0_oe <= 1'b0;
      port_d_line0_pullup <= 1'b0;
    end else begin
      port_d_line0_out <= port_d_out_bit0;
      port_d_line0_oe <= !rx_enable_bit && port_d_dir_bit0;
      // Pull-up follows the port output bit whenever the pin is an input
      port_d_line0_pullup <= port_d_out_bit0 && (rx_enable_bit || !port_d_dir_bit0);
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_armed;
    ##1 (state_reg == URX_START);
  endsequence

  sequence s_stored;
    ##1 rx_complete_flag;
  endsequence

  AST_TX_TAKEOVER: assert property (@(posedge clock) disable iff (sys_rst)
    tx_enable_bit |=> port_d_line1_oe && (port_d_line1_out == $past(tx_line_bit)))
    else $error("transmit pin not taken over");

  AST_RX_INPUT: assert property (@(posedge clock) disable iff (sys_rst)
    rx_enable_bit |=> !port_d_line0_oe && (port_d_line0_pullup == $past(port_d_out_bit0)))
    else $error("receive pin not forced to input");

  AST_RX_RELEASE: assert property (@(posedge clock) disable iff (sys_rst)
    !rx_enable_bit |=> (port_d_line0_oe == $past(port_d_dir_bit0)) && (state_reg == URX_IDLE))
    else $error("disabled receiver kept the pin or ran");

  AST_START_ARM: assert property (@(posedge clock) disable iff (sys_rst)
    (rx_enable_bit && state_reg == URX_IDLE && sample_tick && !smp.line) |-> s_armed)
    else $error("low sample in idle did not start a frame");

  AST_NOISE_REJECT: assert property (@(posedge clock) disable iff (sys_rst)
    (rx_enable_bit && state_reg == URX_START && smp.bit_done && smp.bit_val) |=> state_reg == URX_IDLE)
    else $error("noisy start bit accepted");

  AST_STORE: assert property (@(posedge clock) disable iff (sys_rst)
    accept |-> s_stored and ##1 (serial_data_reg == $past(rx_byte)))
    else $error("completed character not stored");

  AST_FRAME_ERR: assert property (@(posedge clock) disable iff (sys_rst)
    accept |=> frame_error_flag == !$past(stop_ok))
    else $error("frame error flag wrong after stop bit");

  AST_OVERRUN_DROP: assert property (@(posedge clock) disable iff (sys_rst)
    over_evt |=> $stable(serial_data_reg) && or_pending_reg)
    else $error("overrun byte stored or not held pending");

  AST_MP_IGNORE: assert property (@(posedge clock) disable iff (sys_rst)
    ignore |=> $stable(serial_data_reg) && $stable(frame_error_flag) && (rx_complete_flag == $past(unread)))
    else $error("ignored data byte changed state");

  AST_READ_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (data_rd && !accept) |=> !rx_complete_flag)
    else $error("read did not clear receive complete");

  AST_NINTH: assert property (@(posedge clock) disable iff (sys_rst)
    (accept && nine_bit_select) |=> rx_ninth_bit == $past(shift_reg[8]))
    else $error("ninth bit not loaded");

  AST_OVERRUN_SHOW: assert property (@(posedge clock) disable iff (sys_rst)
    (data_rd && or_pending_reg) |=> overrun_flag)
    else $error("pending overrun not shown after read");

  AST_OVERRUN_CLEAR: assert property (@(posedge clock) disable iff (sys_rst)
    (accept && !data_rd) |=> !overrun_flag)
    else $error("overrun flag kept after a stored character");

  AST_RX_OFF_HOLD: assert property (@(posedge clock) disable iff (sys_rst)
    !rx_enable_bit |=> $stable(frame_error_flag) && !$rose(rx_complete_flag))
    else $error("disabled receiver changed its flags");

  AST_STOP_IDLE: assert property (@(posedge clock) disable iff (sys_rst)
    (state_reg == URX_STOP && smp.bit_done) |=> state_reg == URX_IDLE)
    else $error("receiver did not return to idle after the stop bit");

  AST_MP_ADDR: assert property (@(posedge clock) disable iff (sys_rst)
    (frame_end && multiproc_mode_bit && is_addr && !unread) |=> rx_complete_flag)
    else $error("address byte not received in multiprocessor mode");

  AST_LOW_STOP_DATA: assert property (@(posedge clock) disable iff (sys_rst)
    (accept && !nine_bit_select && !stop_ok) |=> rx_complete_flag && frame_error_flag)
    else $error("low stop byte did not set both flags");

endmodule : urx_top

// [urx_node_model.sv]
// Purpose: Far serial node that sends characters into the receive pin.
// Assumes: Bit edges line up with sample ticks, sixteen (eight) ticks per bit.
// Notes: The node always drives the line; idle level is high.
`timescale 1ns/1ps
module urx_node_model (
  input wire logic clock,
  input wire logic sample_tick,
  input wire logic double_speed_bit,
  output logic serial_in_pin
);
  initial serial_in_pin = 1'b1;

  task automatic ticks(input int n);
    repeat (n) @(posedge clock iff sample_tick);
  endtask : ticks

  // ---------------------------------------------------------------
  // Character: start, data LSB first, optional ninth bit, stop
  // ---------------------------------------------------------------
  task automatic send_frame(input logic [8:0] word, input logic nine, input logic stop_val);
    int spb;
    spb = double_speed_bit ? 8 : 16;
    ticks(1);
    serial_in_pin <= 1'b0;
    ticks(spb);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      serial_in_pin <= word[i];
      ticks(spb);
    end
    serial_in_pin <= stop_val;
    ticks(spb);
    serial_in_pin <= 1'b1;
    // One idle bit, so a low stop bit is not mistaken for the next start
    ticks(spb);
  endtask : send_frame

  // Short low spike, to be taken for noise
  task automatic pulse_low(input int n);
    ticks(1);
    serial_in_pin <= 1'b0;
    ticks(n);
    serial_in_pin <= 1'b1;
  endtask : pulse_low
endmodule : urx_node_model

// [urx_top_tb_top.sv]
// Purpose: Self-checking bench of the receive block.
// Assumes: Tick every eight clocks, so one bit is 128 clocks, 64 in double speed.
// Notes: Ordinary characters come from a row table; awkward cases follow.
`timescale 1ns/1ps
module urx_top_tb_top;
  import urx_pkg::*;
  typedef struct packed {
    logic [8:0] word;
    logic nine;
    logic stop;
    logic mp;
    logic dbl;
  } urx_row_s;
  localparam urx_row_s rows [0:10] = '{{9'h055, 4'h4}, {9'h0a3, 4'h0}, {9'h03c, 4'h4}, {9'h181, 4'hc},
    {9'h07e, 4'hc}, {9'h0c5, 4'h5}, {9'h012, 4'h6}, {9'h099, 4'h2}, {9'h121, 4'he}, {9'h044, 4'ha},
    {9'h066, 4'h0}};
  logic clock, sys_rst, sample_tick, rx_enable_bit, tx_enable_bit, nine_bit_select, multiproc_mode_bit;
  logic double_speed_bit, tx_ninth_bit, data_wr, data_rd, tx_line_bit, serial_in_pin;
  logic port_d_dir_bit0, port_d_dir_bit1, port_d_out_bit0, port_d_out_bit1;
  urx_byte_t wr_data, serial_data_reg, exp_data;
  urx_word_t tx_data_reg;
  logic tx_data_written, rx_complete_flag, frame_error_flag, overrun_flag, rx_ninth_bit;
  logic port_d_line0_out, port_d_line0_oe, port_d_line0_pullup, port_d_line1_out, port_d_line1_oe;
  logic exp_fe, exp_nb, acc;
  logic [3:0] v;
  logic [2:0] tick_cnt = 3'h0;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  urx_top i_dut (.clock, .sys_rst, .sample_tick, .rx_enable_bit, .tx_enable_bit, .nine_bit_select,
    .multiproc_mode_bit, .double_speed_bit, .tx_ninth_bit, .data_wr, .data_rd, .wr_data, .tx_line_bit,
    .serial_in_pin, .port_d_dir_bit0, .port_d_dir_bit1, .port_d_out_bit0, .port_d_out_bit1,
    .serial_data_reg, .tx_data_reg, .tx_data_written, .rx_complete_flag, .frame_error_flag, .overrun_flag,
    .rx_ninth_bit, .port_d_line0_out, .port_d_line0_oe, .port_d_line0_pullup, .port_d_line1_out,
    .port_d_line1_oe);
  urx_node_model i_node (.clock, .sample_tick, .double_speed_bit, .serial_in_pin);

  // ---------------------------------------------------------------
  // Clock, oversample tick, hang guard
  // ---------------------------------------------------------------
  initial clock = 1'b0;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    tick_cnt <= tick_cnt + 3'h1;
    sample_tick <= (tick_cnt == 3'h7);
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      fails++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_clk

  task automatic read_data;
    @(posedge clock);
    data_rd <= 1'b1;
    @(posedge clock);
    data_rd <= 1'b0;
    wait_clk(1);
  endtask : read_data

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {rx_enable_bit, tx_enable_bit, nine_bit_select, multiproc_mode_bit, double_speed_bit} = 5'h10;
    {tx_ninth_bit, data_wr, data_rd, tx_line_bit} = 4'h1;
    {port_d_dir_bit0, port_d_dir_bit1, port_d_out_bit0, port_d_out_bit1} = 4'h0;
    wr_data = 8'h00;
    exp_data = 8'h00;
    exp_fe = 1'b0;
    exp_nb = 1'b1;
    wait_clk(10);
    chk(9'({rx_complete_flag, frame_error_flag, overrun_flag}), 9'h000);
    chk(9'({rx_ninth_bit, port_d_line0_oe, port_d_line1_oe}), 9'h004);
    chk(9'(serial_data_reg), 9'h000);
    chk(tx_data_reg, 9'h000);
    wait_clk(1);
    @(posedge clock);
    sys_rst <= 1'b0;
    // Pin takeover over all 16 values of paired enables, paired directions, paired output bits and tx_line_bit
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      @(posedge clock);
      {rx_enable_bit, tx_enable_bit, port_d_dir_bit0, port_d_dir_bit1} <= {v[3], v[3], v[2], v[2]};
      {port_d_out_bit0, port_d_out_bit1, tx_line_bit} <= {v[1], v[1], v[0]};
      wait_clk(2);
      chk(9'(port_d_line1_oe), 9'(v[3] | v[2]));
      chk(9'(port_d_line1_out), 9'(v[3] ? v[0] : v[1]));
      chk(9'(port_d_line0_oe), 9'(!v[3] & v[2]));
      chk(9'(port_d_line0_pullup), 9'(v[1] & (v[3] | !v[2])));
      chk(9'(port_d_line0_out), 9'(v[1]));
    end
    @(posedge clock);
    tx_ninth_bit <= 1'b1;
    wr_data <= 8'hb7;
    @(posedge clock);
    data_wr <= 1'b1;
    @(posedge clock);
    data_wr <= 1'b0;
    #1;
    chk(9'(tx_data_written), 9'h001);
    chk(tx_data_reg, 9'h1b7);
    chk(9'(serial_data_reg), 9'(exp_data));
    wait_clk(1);
    chk(9'(tx_data_written), 9'h000);
    for (int r = 0; r < 11; r++) begin
      @(posedge clock);
      nine_bit_select <= rows[r].nine;
      multiproc_mode_bit <= rows[r].mp;
      double_speed_bit <= rows[r].dbl;
      @(posedge clock);
      i_node.send_frame(rows[r].word, rows[r].nine, rows[r].stop);
      acc = !(rows[r].mp && (rows[r].nine ? !rows[r].word[8] : !rows[r].stop));
      if (acc) begin
        exp_data = rows[r].word[7:0];
        exp_fe = !rows[r].stop;
        if (rows[r].nine) exp_nb = rows[r].word[8];
      end
      wait_clk(4);
      chk(9'(serial_data_reg), 9'(exp_data));
      chk(9'(rx_complete_flag), 9'(acc));
      chk(9'(frame_error_flag), 9'(exp_fe));
      chk(9'(rx_ninth_bit), 9'(exp_nb));
      read_data();
      chk(9'(rx_complete_flag), 9'h000);
    end
    @(posedge clock);
    {nine_bit_select, multiproc_mode_bit, double_speed_bit} <= 3'h0;
    // Samples 1 to 8 low, 9 and 10 high: rejected as a spike
    i_node.pulse_low(8);
    wait_clk(1500);
    chk(9'(rx_complete_flag), 9'h000);
    i_node.send_frame(9'h0e1, 1'b0, 1'b1);
    wait_clk(4);
    chk(9'(serial_data_reg), 9'h0e1);
    chk(9'(frame_error_flag), 9'h000);
    read_data();
    // Second character lands while the first is unread
    i_node.send_frame(9'h0a5, 1'b0, 1'b1);
    i_node.send_frame(9'h05a, 1'b0, 1'b1);
    wait_clk(4);
    chk(9'(serial_data_reg), 9'h0a5);
    chk(9'(overrun_flag), 9'h000);
    read_data();
    chk(9'(overrun_flag), 9'h001);
    chk(9'(serial_data_reg), 9'h0a5);
    i_node.send_frame(9'h0f0, 1'b0, 1'b1);
    wait_clk(4);
    chk(9'(serial_data_reg), 9'h0f0);
    chk(9'(overrun_flag), 9'h000);
    read_data();
    @(posedge clock);
    rx_enable_bit <= 1'b0;
    i_node.send_frame(9'h033, 1'b0, 1'b0);
    wait_clk(4);
    chk(9'({rx_complete_flag, frame_error_flag}), 9'h000);
    chk(9'(serial_data_reg), 9'h0f0);
    // Reset in mid-run must clear held data
    @(posedge clock);
    sys_rst <= 1'b1;
    wait_clk(2);
    chk(9'(serial_data_reg), 9'h000);
    chk(tx_data_reg, 9'h000);
    @(posedge clock);
    sys_rst <= 1'b0;
    wait_clk(2);
    chk(9'(port_d_line1_oe), 9'h001);
    stop_test();
  end
endmodule : urx_top_tb_top
